// File: aspn_serial.sv
// nine-bit asynchronous serial port engine with apb register access
`default_nettype none
`include "aspn_defines.svh"
module aspn_serial (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire aspn_pkg::aspn_addr_t paddr,
    input  wire aspn_pkg::aspn_word_t pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output aspn_pkg::aspn_word_t    prdata,
    input  wire logic               timer1_ovf,
    input  wire logic               rxd,
    output logic                    txd
);
    import aspn_pkg::*;

    logic [7:0] sctl_r;
    logic [7:0] pctl_r;
    logic [7:0] cctl_r;
    logic [7:0] rx_buf_r;
    logic       pready_r;
    logic       pslverr_r;
    aspn_word_t prdata_r;
    logic       txd_r;
    logic       wr_done;
    logic       wr_sctl;
    logic       wr_serial_buffer;
    aspn_mode_t mode;
    logic       dbl;
    logic       ren;
    logic       filt;

    // address decode for the error answer; the read mux decodes paddr in its own case
    function automatic logic addr_hit(input aspn_addr_t a);
        addr_hit = (a == `ASPN_OFF_SCTL) || (a == `ASPN_OFF_SERIAL_BUFFER) ||
                   (a == `ASPN_OFF_PCTL) || (a == `ASPN_OFF_CCTL);
    endfunction : addr_hit

    assign mode    = sctl_r[`ASPN_SC_MODE_HI:`ASPN_SC_MODE_LO];
    assign dbl     = pctl_r[`ASPN_PC_DBL];
    assign ren     = sctl_r[`ASPN_SC_REN];
    assign filt    = sctl_r[`ASPN_SC_FILT];
    assign wr_done = psel && penable && pready_r && pwrite && !pslverr_r;
    assign wr_sctl = wr_done && (paddr == `ASPN_OFF_SCTL);
    assign wr_serial_buffer = wr_done && (paddr == `ASPN_OFF_SERIAL_BUFFER);

    // apb answer: one wait state, so read data can come from a flop
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                pslverr_r <= !addr_hit(paddr);
                prdata_r  <= 32'h0000_0000;
                if (!pwrite) begin
                    unique case (paddr)
                        `ASPN_OFF_SCTL: prdata_r[7:0] <= sctl_r;
                        `ASPN_OFF_SERIAL_BUFFER: prdata_r[7:0] <= rx_buf_r;
                        `ASPN_OFF_PCTL: prdata_r[7:0] <= pctl_r;
                        `ASPN_OFF_CCTL: prdata_r[7:0] <= cctl_r;
                        default:        prdata_r      <= 32'h0000_0000;
                    endcase
                end
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // doubler and converter control; only the doubler bit and the baud-source bit act
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pctl_r <= `ASPN_PCTL_RST;
            cctl_r <= `ASPN_CCTL_RST;
        end else if (wr_done) begin
            if (paddr == `ASPN_OFF_PCTL)
                pctl_r <= {pwdata[7], 7'h00};
            if (paddr == `ASPN_OFF_CCTL) begin
                cctl_r <= pwdata[7:0];
                cctl_r[`ASPN_CC_RSVD] <= 1'b0; // reserved, reads zero
            end
        end
    end

    // 16x sample tick: mode 2 divider, internal generator or timer 1
    logic        tick_r;
    logic [1:0]  m2_cnt_r;
    logic [12:0] brg_acc_r;
    logic        t1_half_r;
    logic [12:0] brg_sum;
    logic [1:0]  m2_last;
    assign brg_sum = brg_acc_r + (dbl ? `ASPN_BRG_STEP_FAST
                                      : `ASPN_BRG_STEP_SLOW);
    assign m2_last = dbl ? `ASPN_M2_LAST_FAST : `ASPN_M2_LAST_SLOW;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tick_r    <= 1'b0;
            m2_cnt_r  <= 2'h0;
            brg_acc_r <= 13'h0000;
            t1_half_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (mode == ASPN_MODE_2) begin
                m2_cnt_r <= (m2_cnt_r == m2_last) ? 2'h0 : m2_cnt_r + 2'h1;
                tick_r   <= (m2_cnt_r == m2_last);
            end else if (mode != ASPN_MODE_SHIFT) begin
                if (cctl_r[`ASPN_CC_BAUD]) begin
                    // fractional accumulator keeps the 2500 ratio exact
                    if (brg_sum >= `ASPN_BRG_DIV) begin
                        brg_acc_r <= brg_sum - `ASPN_BRG_DIV;
                        tick_r    <= 1'b1;
                    end else begin
                        brg_acc_r <= brg_sum;
                    end
                end else if (timer1_ovf) begin
                    t1_half_r <= !t1_half_r;
                    tick_r    <= dbl || t1_half_r;
                end
            end
        end
    end

    // transmitter: bit times follow its own divide-by-16 counter
    aspn_tx_e   tx_state_r;
    logic [3:0] tx_cnt_r;
    logic [8:0] tx_sh_r;
    logic       tx_req_r;
    logic       tx_first_r;
    logic       ti_set_r;
    logic       tx_roll;
    logic       tx_last;
    assign tx_roll = tick_r && (tx_cnt_r == `ASPN_CNT_LAST);
    assign tx_last = !tx_first_r && (tx_sh_r[8:2] == 7'h00) && tx_sh_r[1];
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_r <= ASPN_TX_IDLE;
            tx_cnt_r   <= 4'h0;
            tx_sh_r    <= 9'h000;
            tx_req_r   <= 1'b0;
            tx_first_r <= 1'b0;
            ti_set_r   <= 1'b0;
        end else begin
            ti_set_r <= 1'b0;
            if (tick_r)
                tx_cnt_r <= tx_cnt_r + 4'h1;
            unique case (tx_state_r)
                ASPN_TX_IDLE: begin
                    if (tx_roll && tx_req_r) begin
                        tx_state_r <= ASPN_TX_START;
                        tx_req_r   <= 1'b0;
                    end
                end
                ASPN_TX_START: begin
                    if (tx_roll) begin
                        tx_state_r <= ASPN_TX_DATA;
                        tx_first_r <= 1'b1;
                    end
                end
                ASPN_TX_DATA: begin
                    if (tx_roll) begin
                        tx_first_r <= 1'b0;
                        tx_sh_r <= {tx_first_r && mode != ASPN_MODE_1,
                                    tx_sh_r[8:1]};
                        if (tx_last) begin
                            tx_state_r <= ASPN_TX_IDLE;
                            ti_set_r   <= 1'b1;
                        end
                    end
                end
            endcase
            // a new write reloads the shifter even in the middle of a frame
            if (wr_serial_buffer) begin
                tx_sh_r  <= {mode == ASPN_MODE_1 ? 1'b1
                                  : sctl_r[`ASPN_SC_TB8], pwdata[7:0]};
                tx_req_r <= 1'b1;
            end
        end
    end

    // line driver: idle high, start low, then shifter output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            txd_r <= 1'b1;
        else if (tx_state_r == ASPN_TX_START)
            txd_r <= 1'b0;
        else if (tx_state_r == ASPN_TX_DATA)
            txd_r <= tx_sh_r[0];
        else
            txd_r <= 1'b1;
    end

    // receiver: edge hunt, majority of three, nine-bit shifter
    aspn_rx_e   rx_state_r;
    logic [3:0] rx_cnt_r;
    logic [8:0] rx_sh_r;
    logic       rx_first_r;
    logic       rxd_last_r;
    logic       samp_a_r;
    logic       samp_b_r;
    logic       ri_set_r;
    logic       rb8_set_r;
    logic       rb8_val_r;
    logic       maj;
    logic       decide;
    logic       rx_final;
    logic       rx_take;
    assign maj      = (samp_a_r & samp_b_r) | (samp_a_r & rxd) |
                      (samp_b_r & rxd);
    assign decide   = tick_r && rx_state_r == ASPN_RX_BITS &&
                      rx_cnt_r == `ASPN_SAMP_C;
    assign rx_final = decide && !rx_first_r && !rx_sh_r[8];
    assign rx_take  = rx_final && !sctl_r[`ASPN_SC_RI] &&
                      (!filt || maj);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_state_r <= ASPN_RX_HUNT;
            rx_cnt_r   <= 4'h0;
            rx_sh_r    <= 9'h1FF;
            rx_first_r <= 1'b0;
            rxd_last_r <= 1'b1;
            samp_a_r   <= 1'b1;
            samp_b_r   <= 1'b1;
            ri_set_r   <= 1'b0;
            rb8_set_r  <= 1'b0;
            rb8_val_r  <= 1'b0;
            rx_buf_r   <= 8'h00;
        end else begin
            ri_set_r  <= 1'b0;
            rb8_set_r <= 1'b0;
            if (tick_r) begin
                rxd_last_r <= rxd;
                rx_cnt_r   <= rx_cnt_r + 4'h1;
                if (rx_cnt_r == `ASPN_SAMP_A)
                    samp_a_r <= rxd;
                if (rx_cnt_r == `ASPN_SAMP_B)
                    samp_b_r <= rxd;
                unique case (rx_state_r)
                    ASPN_RX_HUNT: begin
                        if (ren && rxd_last_r && !rxd) begin
                            rx_cnt_r   <= 4'h0;
                            rx_sh_r    <= 9'h1FF;
                            rx_first_r <= 1'b1;
                            rx_state_r <= ASPN_RX_BITS;
                        end
                    end
                    ASPN_RX_BITS: begin
                        if (rx_cnt_r == `ASPN_SAMP_C) begin
                            rx_first_r <= 1'b0;
                            rx_sh_r    <= {rx_sh_r[7:0], maj};
                            if (rx_first_r && maj)
                                rx_state_r <= ASPN_RX_HUNT;
                            else if (rx_final)
                                rx_state_r <= (mode == ASPN_MODE_1)
                                    ? ASPN_RX_HUNT : ASPN_RX_STOP;
                        end
                    end
                    ASPN_RX_STOP: begin
                        // stop bit is timed but never looked at
                        if (rx_cnt_r == `ASPN_SAMP_C)
                            rx_state_r <= ASPN_RX_HUNT;
                    end
                endcase
            end
            if (rx_take) begin
                rx_buf_r  <= {rx_sh_r[0], rx_sh_r[1], rx_sh_r[2], rx_sh_r[3],
                              rx_sh_r[4], rx_sh_r[5], rx_sh_r[6], rx_sh_r[7]};
                rb8_set_r <= 1'b1;
                rb8_val_r <= maj;
                ri_set_r  <= 1'b1;
            end
        end
    end

    // serial control: hardware setting of a flag wins over a clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sctl_r <= `ASPN_SCTL_RST;
        end else begin
            if (wr_sctl)
                sctl_r <= pwdata[7:0];
            if (rb8_set_r)
                sctl_r[`ASPN_SC_RB8] <= rb8_val_r;
            if (ri_set_r)
                sctl_r[`ASPN_SC_RI] <= 1'b1;
            if (ti_set_r)
                sctl_r[`ASPN_SC_TI] <= 1'b1;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;
    assign txd     = txd_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_take;
        rx_final && !sctl_r[`ASPN_SC_RI] && (!filt || maj)
            |-> ##2 sctl_r[`ASPN_SC_RI] &&
                sctl_r[`ASPN_SC_RB8] == $past(maj, 2);
    endproperty
    a_take: assert property (p_take) else $error("frame not taken");
    property p_lose;
        rx_final && sctl_r[`ASPN_SC_RI]
            |=> $stable(rx_buf_r) ##1 $stable(rx_buf_r);
    endproperty
    a_lose: assert property (p_lose) else $error("buffer overwritten");
    property p_filter;
        rx_final && filt && !maj |=> !ri_set_r && $stable(rx_buf_r);
    endproperty
    a_filter: assert property (p_filter) else $error("filter leak");
    property p_hunt1;
        rx_final && mode == ASPN_MODE_1 |=> rx_state_r == ASPN_RX_HUNT;
    endproperty
    a_hunt1: assert property (p_hunt1) else $error("no rehunt");
    property p_hunt23;
        tick_r && rx_state_r == ASPN_RX_STOP && rx_cnt_r == `ASPN_SAMP_C
            |=> rx_state_r == ASPN_RX_HUNT;
    endproperty
    a_hunt23: assert property (p_hunt23) else $error("stop wait");
    property p_false;
        decide && rx_first_r && maj |=> rx_state_r == ASPN_RX_HUNT;
    endproperty
    a_false: assert property (p_false) else $error("false start");
    property p_edge;
        tick_r && rx_state_r == ASPN_RX_HUNT && ren && rxd_last_r && !rxd
            |=> rx_sh_r == 9'h1FF && rx_cnt_r == 4'h0;
    endproperty
    a_edge: assert property (p_edge) else $error("edge reset");
    property p_start;
        tx_state_r == ASPN_TX_IDLE && tx_roll && tx_req_r
            |=> tx_state_r == ASPN_TX_START ##1 !txd_r;
    endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_load;
        wr_serial_buffer && mode[1] |=> tx_req_r && tx_sh_r[8] == $past(sctl_r[3]);
    endproperty
    a_load: assert property (p_load) else $error("ninth not loaded");
    property p_stopins;
        tx_roll && tx_state_r == ASPN_TX_DATA && tx_first_r && mode[1]
            && !wr_serial_buffer |=> tx_sh_r[8];
    endproperty
    a_stopins: assert property (p_stopins) else $error("no stop");
    property p_m2fast;
        tick_r && mode == ASPN_MODE_2 && dbl && !wr_done
            |=> !tick_r ##1 tick_r;
    endproperty
    a_m2fast: assert property (p_m2fast) else $error("mode 2 /32");
    property p_m2slow;
        tick_r && mode == ASPN_MODE_2 && !dbl && !psel
            |=> !tick_r [*3] ##1 tick_r;
    endproperty
    a_m2slow: assert property (p_m2slow) else $error("mode 2 /64");
    c_rx_ok: cover property (ri_set_r);
    c_tx_ok: cover property (ti_set_r);
    c_false: cover property (decide && rx_first_r && maj);
endmodule : aspn_serial
`default_nettype wire

// File: aspn_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ASPN_DEFINES_SVH
`define ASPN_DEFINES_SVH
`define ASPN_OFF_SCTL      8'h00
`define ASPN_OFF_SERIAL_BUFFER      8'h04
`define ASPN_OFF_PCTL      8'h08
`define ASPN_OFF_CCTL      8'hD8
`define ASPN_SC_MODE_HI    7
`define ASPN_SC_MODE_LO    6
`define ASPN_SC_FILT       5
`define ASPN_SC_REN        4
`define ASPN_SC_TB8        3
`define ASPN_SC_RB8        2
`define ASPN_SC_TI         1
`define ASPN_SC_RI         0
`define ASPN_PC_DBL        7
`define ASPN_CC_BAUD       7
`define ASPN_CC_RSVD       5
`define ASPN_SCTL_RST      8'h00
`define ASPN_PCTL_RST      8'h00
`define ASPN_CCTL_RST      8'h00
`define ASPN_BRG_DIV       13'h09C4
`define ASPN_BRG_STEP_SLOW 13'h0010
`define ASPN_BRG_STEP_FAST 13'h0020
`define ASPN_M2_LAST_FAST  2'h1
`define ASPN_M2_LAST_SLOW  2'h3
`define ASPN_SAMP_A        4'h7
`define ASPN_SAMP_B        4'h8
`define ASPN_SAMP_C        4'h9
`define ASPN_CNT_LAST      4'hF
`endif

// File: aspn_pkg.sv
// shared types of the nine-bit asynchronous serial port
`default_nettype none
package aspn_pkg;
    typedef logic [7:0]  aspn_addr_t;
    typedef logic [31:0] aspn_word_t;
    typedef logic [1:0]  aspn_mode_t;
    typedef enum logic [1:0] {
        ASPN_MODE_SHIFT, ASPN_MODE_1, ASPN_MODE_2, ASPN_MODE_3
    } aspn_mode_e;
    typedef enum {ASPN_TX_IDLE, ASPN_TX_START, ASPN_TX_DATA} aspn_tx_e;
    typedef enum {ASPN_RX_HUNT, ASPN_RX_BITS, ASPN_RX_STOP} aspn_rx_e;
endpackage : aspn_pkg
`default_nettype wire

// File: aspn_remote.sv
// remote serial party: drives frames onto rxd, captures frames from txd
`default_nettype none
module aspn_remote (
    input  wire logic       ref_clk,
    input  wire logic       txd,
    output var  logic       rxd,
    input  wire integer     bit_clks,
    input  wire integer     nbits,
    output var  logic [9:0] got,
    output var  logic       got_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    // line rests high between frames, as an idle serial line does
    initial begin
        rxd = 1'b1;
        got = 10'h000;
        got_stb = 1'b0;
    end

    // start bit 0, then nbits-1 bits lsb first, each bit_clks long
    task automatic send(input logic [9:0] bits);
        for (int i = 0; i < nbits; i++) begin
            @(posedge ref_clk);
            rxd <= (i == 0) ? 1'b0 : bits[i - 1];
            repeat (bit_clks - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd <= 1'b1;
    endtask : send

    // short low pulse, too short to pass the majority vote
    task automatic glitch(input int n);
        @(posedge ref_clk);
        rxd <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rxd <= 1'b1;
    endtask : glitch

    // capture: timed from the falling edge, each bit sampled mid-bit
    initial forever begin
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge ref_clk);
        got = 10'h000;
        for (int i = 0; i < nbits - 1; i++) begin
            repeat (bit_clks) @(posedge ref_clk);
            got[i] = txd;
        end
        @(posedge ref_clk);
        got_stb = 1'b1;
        @(posedge ref_clk);
        got_stb = 1'b0;
    end
endmodule : aspn_remote
`default_nettype wire

// File: aspn_serial_test.sv
// self-checking bench for the nine-bit serial port
`default_nettype none
`include "aspn_defines.svh"
module aspn_serial_test;
    import aspn_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic       timer1_ovf, txd, rxd, got_stb, err;
    logic [1:0] ovf_cnt;
    logic [7:0] last;
    logic [9:0] got;
    logic [9:0] exp_q[$];
    aspn_addr_t paddr;
    aspn_word_t pwdata, prdata, rd;
    aspn_mode_e cur_m;
    int         bit_clks, nbits, error_cnt, checks_done;

    aspn_serial i_aspn_serial (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .timer1_ovf(timer1_ovf), .rxd(rxd), .txd(txd));
    aspn_remote i_aspn_remote (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
        .bit_clks(bit_clks), .nbits(nbits), .got(got), .got_stb(got_stb));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // timer overflow pulse every fourth clock
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ovf_cnt    <= 2'h0;
            timer1_ovf <= 1'b0;
        end else begin
            ovf_cnt    <= ovf_cnt + 2'h1;
            timer1_ovf <= (ovf_cnt == 2'h3);
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic fail(input string msg);
        error_cnt++;
        $display("Error at %0t: %s", $time, msg);
        results();
    endtask : fail

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: read %h expected %h", $time, g, e);
        end
    endtask : chk_reg

    task automatic chk_frame(input logic [9:0] g, input logic [9:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: frame %h expected %h", $time, g, e);
        end
    endtask : chk_frame

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input aspn_addr_t a,
                       input aspn_word_t d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) fail("bus timeout");
        @(posedge ref_clk);
    endtask : apb

    function automatic aspn_word_t sc(aspn_mode_e m, logic f, logic t8);
        return {24'h000000, m, f, 1'b1, t8, 3'b000};
    endfunction : sc

    // send one byte; the expected frame goes to the queue first
    task automatic tx_frame(input logic t8);
        logic [7:0] d;
        int         n;
        d = 8'($urandom);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b0, t8));
        if (cur_m == ASPN_MODE_1) exp_q.push_back({2'b01, d});
        else exp_q.push_back({1'b1, t8, d});
        apb(1'b1, `ASPN_OFF_SERIAL_BUFFER, {24'h000000, d});
        for (n = 0; n < 4000; n++) begin
            apb(1'b0, `ASPN_OFF_SCTL, '0);
            if (rd[`ASPN_SC_TI] === 1'b1) break;
        end
        if (n >= 4000) fail("transmit flag timeout");
        repeat (bit_clks) @(posedge ref_clk);
        chk_reg(32'(exp_q.size()), 32'h0);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b0, t8));
    endtask : tx_frame

    // receive one frame, then look at the flags and the buffer
    task automatic rx_frame(input logic [9:0] bits, input logic take,
                            input logic ri_exp);
        i_aspn_remote.send(bits);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, `ASPN_OFF_SCTL, '0);
        chk_reg(32'(rd[`ASPN_SC_RI]), 32'(ri_exp));
        if (take) begin
            chk_reg(32'(rd[`ASPN_SC_RB8]), 32'(bits[8]));
            last = bits[7:0];
        end
        apb(1'b0, `ASPN_OFF_SERIAL_BUFFER, '0);
        chk_reg(rd, {24'h000000, last});
    endtask : rx_frame

    // the oldest expected frame is compared with each captured one
    initial forever begin
        @(posedge got_stb);
        if (exp_q.size() == 0) fail("unexpected frame");
        else chk_frame(got, exp_q.pop_front());
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {nrst, last} = '0;
        error_cnt = 0;
        checks_done = 0;
        bit_clks = 32;
        nbits = 11;
        cur_m = ASPN_MODE_2;
        void'($urandom(32'hD6743F7B));
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk_reg(32'(txd), 32'h1);
        apb(1'b0, `ASPN_OFF_SCTL, '0);
        chk_reg(rd, 32'h0);
        apb(1'b0, `ASPN_OFF_PCTL, '0);
        chk_reg(rd, 32'h0);
        apb(1'b0, `ASPN_OFF_CCTL, '0);
        chk_reg(rd, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        chk_reg(32'(err), 32'h1);
        apb(1'b0, 8'h10, '0);
        chk_reg({rd[31:1], err}, 32'h1);
        apb(1'b1, `ASPN_OFF_CCTL, 32'h000000FF);
        apb(1'b0, `ASPN_OFF_CCTL, '0);
        chk_reg(rd, 32'h000000DF);
        apb(1'b1, `ASPN_OFF_CCTL, 32'h0);
        $display("test registers done");
        apb(1'b1, `ASPN_OFF_PCTL, 32'h80);
        tx_frame(1'b1);
        tx_frame(1'b0);
        bit_clks = 64;
        apb(1'b1, `ASPN_OFF_PCTL, 32'h0);
        tx_frame(1'b1);
        $display("test mode 2 transmit done");
        rx_frame({2'b11, 8'($urandom)}, 1'b1, 1'b1);
        rx_frame({2'b10, 8'($urandom)}, 1'b0, 1'b1);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b1, 1'b0));
        rx_frame({2'b10, 8'($urandom)}, 1'b0, 1'b0);
        rx_frame({2'b01, 8'($urandom)}, 1'b1, 1'b1);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b0, 1'b0));
        i_aspn_remote.glitch(8);
        repeat (bit_clks * 2) @(posedge ref_clk);
        apb(1'b0, `ASPN_OFF_SCTL, '0);
        chk_reg(32'(rd[`ASPN_SC_RI]), 32'h0);
        rx_frame({2'b10, 8'($urandom)}, 1'b1, 1'b1);
        $display("test mode 2 receive done");
        cur_m = ASPN_MODE_3;
        bit_clks = 128;
        tx_frame(1'b1);
        rx_frame({2'b11, 8'($urandom)}, 1'b1, 1'b1);
        $display("test mode 3 timer done");
        cur_m = ASPN_MODE_1;
        bit_clks = 1250;
        nbits = 10;
        apb(1'b1, `ASPN_OFF_PCTL, 32'h80);
        apb(1'b1, `ASPN_OFF_CCTL, 32'h80);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b1, 1'b0));
        rx_frame({2'b01, 8'($urandom)}, 1'b1, 1'b1);
        apb(1'b1, `ASPN_OFF_SCTL, sc(cur_m, 1'b1, 1'b0));
        rx_frame({2'b00, 8'($urandom)}, 1'b0, 1'b0);
        tx_frame(1'b0);
        $display("test mode 1 internal rate done");
        results();
    end
endmodule : aspn_serial_test
`default_nettype wire
